// file: hw/ucsc_port_ctrl.sv
// Type-C charging port control: attach, power path, charge scheme
// Operation
// - Rp on both CC; sink shows Rd
// - Attach when CC below open level
// - Tell Rd from Ra; VCONN only on Ra
// - Ra/Ra audio, Rd/Rd debug accessory
// - Sample enable once sense above lockout
// - After start, sink found turns switch on
// - VCONN to the line showing Ra
// - Only auto-detect charging state machine
// - Shorted scheme joins D+ and D-
// - Divider scheme drives 2.7 V both lines
// - 1.2-V scheme timed, then shorted
// - Auto-detect starts in divider scheme
// - Compliant device: switch off, 1.2 V, shorted
// - Shorted until data line released
// - Divider-compliant device stays in divider
// - Enable low means shutdown
// - Overvoltage or undervoltage stops converter
// - Active needs enable, sense, CC detection
// - Buck idle until Rd, then forced PWM
// - Lock switching to valid sync clock
`include "ucsc_cfg.svh"
module ucsc_port_ctrl
    import ucsc_pkg::*;
#(
    parameter int MODE12_CYC  = `UCSC_MODE12_CYC,
    parameter int RELEASE_CYC = `UCSC_RELEASE_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       enAboveThr,
    input  wire logic       senseAboveUvlo,
    input  wire logic       inputOverVolt,
    input  wire logic [1:0] cc1Level,
    input  wire logic [1:0] cc2Level,
    input  wire logic       bc12Detected,
    input  wire logic       dataLineActive,
    input  wire logic       switching_input_a,
    output logic            rpEnable1,
    output logic            rpEnable2,
    output logic            portSwitchOn,
    output logic            vconnOn1,
    output logic            vconnOn2,
    output logic            audioAccessory,
    output logic            debugAccessory,
    output logic            attached,
    output logic            converterOn,
    output logic            bucKRun,
    output logic            forced_continuous_pwm,
    output logic            syncLocked,
    output logic            dataShort,
    output logic            dataDivider,
    output logic            dataPull12,
    output logic            activeMode
);
    localparam int CW  = $clog2(MODE12_CYC + 1);
    localparam int RW  = $clog2(RELEASE_CYC + 1);
    localparam int SW  = $clog2(`UCSC_SYNC_LOSS_CYC + 1);

    logic [6:0] rawIn;
    logic [1:0] syncIn;
    logic       syncPinQ;
    logic       syncPinPrevQ;

    ucsc_sync #(.W(7)) uInSync (
        .clk  (clk),
        .rst  (rst),
        .din  ({enAboveThr, senseAboveUvlo, inputOverVolt, cc1Level, cc2Level}),
        .dout (rawIn)
    );

    ucsc_sync #(.W(3)) uDataSync (
        .clk  (clk),
        .rst  (rst),
        .din  ({bc12Detected, dataLineActive, switching_input_a}),
        .dout ({syncIn[1], syncIn[0], syncPinQ})
    );
    wire       enS    = rawIn[6];
    wire       senseS = rawIn[5];
    wire       ovS    = rawIn[4];
    wire [1:0] cc1S   = rawIn[3:2];
    wire [1:0] cc2S   = rawIn[1:0];
    wire       bcS    = syncIn[1];
    wire       dlS    = syncIn[0];

    // Decode of CC terminations
    wire rd1     = (cc1S == `UCSC_CC_RD);
    wire rd2     = (cc2S == `UCSC_CC_RD);
    wire ra1     = (cc1S == `UCSC_CC_RA);
    wire ra2     = (cc2S == `UCSC_CC_RA);
    wire anyLow  = (cc1S != `UCSC_CC_OPEN) || (cc2S != `UCSC_CC_OPEN);
    wire audioW  = ra1 && ra2;
    wire debugW  = rd1 && rd2;
    wire sinkW   = (rd1 || rd2) && !audioW;
    wire vc1W    = rd2 && ra1;
    wire vc2W    = rd1 && ra2;

    ucsc_pwr_t pwr_q, pwr_d;
    ucsc_chg_t chg_q, chg_d;
    logic [CW-1:0] tmr_q;
    logic [RW-1:0] rel_q;
    logic [SW-1:0] per_q;
    logic [SW-1:0] lastPer_q;

    // Power mode
    wire lockout = ovS || !senseS;
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PwrShutdown: if (senseS && enS) pwr_d = PwrStandby;
            PwrStandby: begin
                if (!enS || !senseS) pwr_d = PwrShutdown;
                else if (anyLow) pwr_d = PwrActive;
            end
            PwrActive: begin
                if (!enS || !senseS) pwr_d = PwrShutdown;
                else if (!anyLow) pwr_d = PwrStandby;
            end
            default: pwr_d = PwrShutdown;
        endcase
    end

    wire activeW = (pwr_d == PwrActive);
    wire runW    = activeW && sinkW && !lockout;
    wire relDone = (rel_q == RW'(RELEASE_CYC));
    wire shortW  = (chg_d == ChgShorted) || (chg_d == ChgMode12);

    // Charge scheme auto-detect
    always_comb begin
        chg_d = chg_q;
        if (pwr_q == PwrShutdown) begin
            chg_d = ChgDivider;
        end else begin
            case (chg_q)
                ChgDivider: if (bcS) chg_d = ChgOff;
                ChgOff:     chg_d = ChgMode12;
                ChgMode12:  if (tmr_q == CW'(MODE12_CYC)) chg_d = ChgShorted;
                ChgShorted: if (relDone) chg_d = ChgDivider;
                default:    chg_d = ChgDivider;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_q <= PwrShutdown;
            chg_q <= ChgDivider;
        end else begin
            pwr_q <= pwr_d;
            chg_q <= chg_d;
        end
    end

    // 1.2-V scheme timer and data line release filter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_q <= '0;
            rel_q <= '0;
        end else begin
            tmr_q <= (chg_q == ChgMode12) ? tmr_q + CW'(1) : '0;
            if (chg_q != ChgShorted || dlS) rel_q <= '0;
            else if (!relDone) rel_q <= rel_q + RW'(1);
        end
    end

    // Sync pin period measure; edges only seen through the synchroniser
    wire syncRise = syncPinQ && !syncPinPrevQ;
    wire perOk    = (per_q >= SW'(`UCSC_SYNC_MIN_CYC)) && (per_q <= SW'(`UCSC_SYNC_MAX_CYC));
    wire lastOk   = (lastPer_q >= SW'(`UCSC_SYNC_MIN_CYC))
                 && (lastPer_q <= SW'(`UCSC_SYNC_MAX_CYC));
    wire perLost  = (per_q == SW'(`UCSC_SYNC_LOSS_CYC));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncPinPrevQ <= 1'b0;
            per_q        <= '0;
            lastPer_q    <= '0;
        end else begin
            syncPinPrevQ <= syncPinQ;
            if (syncRise) begin
                per_q     <= '0;
                lastPer_q <= per_q;
            end else if (!perLost) begin
                per_q <= per_q + SW'(1);
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpEnable1             <= 1'b0;
            rpEnable2             <= 1'b0;
            portSwitchOn          <= 1'b0;
            vconnOn1              <= 1'b0;
            vconnOn2              <= 1'b0;
            audioAccessory        <= 1'b0;
            debugAccessory        <= 1'b0;
            attached              <= 1'b0;
            converterOn           <= 1'b0;
            bucKRun               <= 1'b0;
            forced_continuous_pwm <= 1'b0;
            syncLocked            <= 1'b0;
            dataShort             <= 1'b0;
            dataDivider           <= 1'b0;
            dataPull12            <= 1'b0;
            activeMode            <= 1'b0;
        end else begin
            rpEnable1             <= (pwr_d != PwrShutdown);
            rpEnable2             <= (pwr_d != PwrShutdown);
            // Switch drops for one cycle on a compliant detect, no discharge
            portSwitchOn          <= activeW && sinkW && (chg_d != ChgOff);
            vconnOn1              <= activeW && vc1W;
            vconnOn2              <= activeW && vc2W;
            audioAccessory        <= activeW && audioW;
            debugAccessory        <= activeW && debugW;
            attached              <= activeW && anyLow;
            converterOn           <= activeW && !lockout;
            bucKRun               <= runW;
            forced_continuous_pwm <= runW;
            // Lock needs two good periods in a row, dropped if pin stalls
            syncLocked            <= runW && !perLost && (syncRise ? perOk && lastOk
                                                                   : syncLocked);
            dataShort             <= activeW && shortW;
            dataDivider           <= activeW && (chg_d == ChgDivider);
            dataPull12            <= activeW && (chg_d == ChgMode12);
            activeMode            <= activeW;
        end
    end
endmodule : ucsc_port_ctrl

// file: hw/ucsc_sync.sv
// Two flip-flop synchroniser for a bank of comparator levels
module ucsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : ucsc_sync

// file: inc/ucsc_cfg.svh
// Constants for the charge port controller
`ifndef UCSC_CFG_SVH
`define UCSC_CFG_SVH
`define UCSC_CLK_MHZ          125
`define UCSC_MODE12_US        20
`define UCSC_MODE12_CYC       (`UCSC_MODE12_US * `UCSC_CLK_MHZ)
`define UCSC_RELEASE_US       10
`define UCSC_RELEASE_CYC      (`UCSC_RELEASE_US * `UCSC_CLK_MHZ)
`define UCSC_SYNC_MIN_CYC     42
`define UCSC_SYNC_MAX_CYC     625
`define UCSC_SYNC_LOSS_CYC    1250
`define UCSC_CC_OPEN          2'b00
`define UCSC_CC_RD            2'b01
`define UCSC_CC_RA            2'b10
`endif

// file: inc/ucsc_pkg.sv
// Types for the charge port controller
package ucsc_pkg;
    typedef enum logic [3:0] {
        ChgDivider = 4'b0001,
        ChgMode12  = 4'b0010,
        ChgShorted = 4'b0100,
        ChgOff     = 4'b1000
    } ucsc_chg_t;
    typedef enum logic [2:0] {
        PwrShutdown = 3'b001,
        PwrStandby  = 3'b010,
        PwrActive   = 3'b100
    } ucsc_pwr_t;
endpackage : ucsc_pkg

// file: sim/test_ucsc_port_ctrl.sv
// Self-checking bench for the charge port controller
module test_ucsc_port_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, fl, take = 1'b0, syncRun = 1'b0, flip = 1'b0;
    logic enAboveThr = 1'b0, senseAboveUvlo = 1'b0, inputOverVolt = 1'b0;
    logic switching_input_a = 1'b0;
    logic [2:0] mode = 3'd0;
    logic [1:0] cc1Level, cc2Level;
    logic bc12Detected, dataLineActive, rpEnable1, rpEnable2, portSwitchOn;
    logic vconnOn1, vconnOn2, audioAccessory, debugAccessory, attached;
    logic converterOn, bucKRun, forced_continuous_pwm, syncLocked;
    logic dataShort, dataDivider, dataPull12, activeMode;
    logic [14:0] obs;
    logic [29:0] noteQ[$];
    logic [31:0] rnd = 32'hb5c2;
    int syncCnt = 0, n_mismatch = 0, check_count = 0;
    // Short counts keep the 1.2-V and release phases visible
    ucsc_port_ctrl #(.MODE12_CYC(8), .RELEASE_CYC(4)) u_dut (.*);
    ucsc_sink_model u_sink (.*);
    assign obs = {syncLocked, rpEnable1, rpEnable2, portSwitchOn, vconnOn1, vconnOn2,
        audioAccessory, debugAccessory, attached, activeMode, converterOn, bucKRun,
        dataDivider, dataShort, dataPull12};
    always #4 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Noise on the sync input, or a clean 100-cycle clock
    always @(posedge clk) begin
        rnd <= xs(rnd);
        syncCnt <= (syncCnt == 99) ? 0 : syncCnt + 1;
        switching_input_a <= syncRun ? (syncCnt < 50) : rnd[0];
    end
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: outputs %h, expected %h", $time, seen, exp);
        end
    endtask : check
    always @(posedge clk) begin
        if (take) begin
            check(obs & noteQ[0][14:0], noteQ[0][29:15]);
            noteQ.delete(0);
        end
    end
    task automatic step(input logic e, s, o, input logic [2:0] m, input int cyc,
        input logic [14:0] exp, mask);
        enAboveThr <= e;
        senseAboveUvlo <= s;
        inputOverVolt <= o;
        mode <= m;
        repeat (cyc) @(posedge clk);
        noteQ.push_back({exp & mask, mask});
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
    endtask : step
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        fl = rnd[2];
        flip <= fl;
        step(0, 1, 0, 0, 6, 15'h0000, 15'h3ff8);
        step(1, 1, 0, 0, 6, 15'h3000, 15'h3ff8);
        step(1, 1, 0, 1, 6, 15'h387c, 15'h3fff);
        step(1, 1, 0, 1, 40, 15'h387c, 15'h3fff);
        step(1, 1, 0, 2, 6, fl ? 15'h3c7c : 15'h3a7c, 15'h3fff);
        flip <= !fl;
        step(1, 1, 0, 2, 6, fl ? 15'h3a7c : 15'h3c7c, 15'h3fff);
        step(1, 1, 0, 3, 6, 15'h3140, 15'h3fc8);
        step(1, 1, 0, 4, 6, 15'h38fc, 15'h3fff);
        step(1, 1, 1, 1, 6, 15'h3064, 15'h37f8);
        step(1, 1, 0, 5, 6, 15'h387b, 15'h3fff);
        step(1, 1, 0, 5, 20, 15'h387a, 15'h3fff);
        step(1, 1, 0, 1, 12, 15'h387c, 15'h3fff);
        syncRun <= 1'b1;
        step(1, 1, 0, 1, 450, 15'h787c, 15'h7fff);
        syncRun <= 1'b0;
        step(1, 0, 0, 1, 6, 15'h0000, 15'h3ff8);
        step(0, 1, 0, 1, 6, 15'h0000, 15'h3ff8);
        rst <= 1'b1;
        step(1, 1, 0, 1, 2, 15'h0000, 15'h7fff);
        give_verdict();
    end
    // Whole run needs about 614 cycles
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule : test_ucsc_port_ctrl

// file: sim/ucsc_port_ctrl_props.sv
// Port checker for the charge port controller
`include "ucsc_cfg.svh"
module ucsc_port_ctrl_props #(
    parameter int MODE12_CYC = 8
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       enAboveThr,
    input wire logic       inputOverVolt,
    input wire logic [1:0] cc1Level,
    input wire logic [1:0] cc2Level,
    input wire logic       vconnOn1,
    input wire logic       vconnOn2,
    input wire logic       audioAccessory,
    input wire logic       debugAccessory,
    input wire logic       rpEnable1,
    input wire logic       activeMode,
    input wire logic       attached,
    input wire logic       portSwitchOn,
    input wire logic       converterOn,
    input wire logic       bucKRun,
    input wire logic       forced_continuous_pwm,
    input wire logic       dataShort,
    input wire logic       dataDivider,
    input wire logic       dataPull12
);
    int cnt12_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Length of the running 1.2-V phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt12_q <= 0;
        else cnt12_q <= dataPull12 ? cnt12_q + 1 : 0;
    end
    a_vconn_on_ra: assert property (vconnOn1 |->
        $past(cc1Level, 3) == `UCSC_CC_RA && !vconnOn2)
        else $error("vconn on a line without cable load");
    a_audio_ra_ra: assert property (audioAccessory |-> $past(cc1Level, 3) == `UCSC_CC_RA
        && $past(cc2Level, 3) == `UCSC_CC_RA && !vconnOn1 && !vconnOn2)
        else $error("audio flag without load on both lines");
    a_debug_rd_rd: assert property (debugAccessory |-> $past(cc1Level, 3) == `UCSC_CC_RD
        && $past(cc2Level, 3) == `UCSC_CC_RD)
        else $error("debug flag without sink on both lines");
    a_enable_off: assert property (!$past(enAboveThr, 3) |-> !rpEnable1 && !activeMode)
        else $error("port alive with enable low");
    a_lockout_stop: assert property ($past(inputOverVolt, 3) |-> !converterOn && !bucKRun)
        else $error("converter runs in overvoltage");
    a_switch_active: assert property (portSwitchOn |-> activeMode && attached && rpEnable1)
        else $error("switch on outside active attach");
    a_buck_forced: assert property ((forced_continuous_pwm == bucKRun)
        && (!bucKRun || converterOn))
        else $error("buck runs without forced pwm");
    a_mode12_time: assert property ($fell(dataPull12) |->
        cnt12_q == MODE12_CYC + 1 && dataShort)
        else $error("1.2-V phase length or exit wrong");
    a_scheme_excl: assert property (!(dataDivider && dataShort)
        && (!dataPull12 || dataShort))
        else $error("data line schemes overlap");
    a_mode12_power: assert property ($rose(dataPull12) |-> ##[0:2] portSwitchOn)
        else $error("switch not back on in 1.2-V phase");
endmodule : ucsc_port_ctrl_props
bind ucsc_port_ctrl ucsc_port_ctrl_props #(.MODE12_CYC(MODE12_CYC)) u_props (.*);

// file: sim/ucsc_sink_model.sv
// Attached sink, cable or accessory seen on CC and data lines
`include "ucsc_cfg.svh"
module ucsc_sink_model (
    input  wire logic [2:0] mode,
    input  wire logic       clk,
    input  wire logic       flip,
    output logic      [1:0] cc1Level,
    output logic      [1:0] cc2Level,
    output logic            bc12Detected,
    output logic            dataLineActive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] a, b;
    always_comb begin
        case (mode)
            3'd1, 3'd5: {a, b} = {`UCSC_CC_RD, `UCSC_CC_OPEN};
            3'd2: {a, b} = {`UCSC_CC_RD, `UCSC_CC_RA};
            3'd3: {a, b} = {`UCSC_CC_RA, `UCSC_CC_RA};
            3'd4: {a, b} = {`UCSC_CC_RD, `UCSC_CC_RD};
            default: {a, b} = {`UCSC_CC_OPEN, `UCSC_CC_OPEN};
        endcase
    end
    // Plug orientation swaps lines; detach leaves both open
    always @(posedge clk) begin
        cc1Level <= flip ? b : a;
        cc2Level <= flip ? a : b;
        bc12Detected <= mode == 3'd5;
        dataLineActive <= mode == 3'd5;
    end
endmodule : ucsc_sink_model
